// ### bdwc_pkg.sv
package bdwc_pkg;

  // Register map and reset value
  localparam logic [7:0] BDWC_CTRL_ADDR  = 8'h30;
  localparam logic [7:0] BDWC_CTRL_RESET = 8'h00;

  // Control field positions
  localparam int BDWC_DIV_LSB      = 0;
  localparam int BDWC_DIV_W        = 4;
  localparam int BDWC_WRAP_DIS_BIT = 4;
  localparam int BDWC_WRAP_SEL_BIT = 5;
  localparam int BDWC_RSVD_BIT     = 6;
  localparam int BDWC_BURST_BIT    = 7;

  // Address pointer landmarks
  localparam logic [7:0] BDWC_X_LOW_ADDR  = 8'h0D;
  localparam logic [7:0] BDWC_Z_HIGH_ADDR = 8'h12;
  localparam logic [7:0] BDWC_IFLAG_ADDR  = 8'h14;

  // Counts
  localparam logic [2:0] BDWC_SAMPLE_BYTES = 3'h6;
  localparam logic [5:0] BDWC_MAX_BURST    = 6'h20;
  localparam logic [2:0] BDWC_LAST_BIT     = 3'h7;
  localparam int         BDWC_DIV_CNT_W    = 10;

  typedef enum logic [1:0] {
    BDWC_IDLE = 2'b01,
    BDWC_XFER = 2'b10
  } bdwc_state_e;

  // Division factor for each divider select code
  function automatic logic [9:0] bdwc_divisor(input logic [3:0] sel);
    logic [9:0] d;
    d = 10'h001;
    unique case (sel)
      4'h0: d = 10'h001;
      4'h1: d = 10'h002;
      4'h2: d = 10'h004;
      4'h3: d = 10'h005;
      4'h4: d = 10'h008;
      4'h5: d = 10'h00A;
      4'h6: d = 10'h010;
      4'h7: d = 10'h014;
      4'h8: d = 10'h028;
      4'h9: d = 10'h043;
      4'hA: d = 10'h050;
      4'hB: d = 10'h064;
      4'hC: d = 10'h0C8;
      4'hD: d = 10'h0FA;
      4'hE: d = 10'h1F4;
      4'hF: d = 10'h3E8;
    endcase
    return d;
  endfunction

endpackage

// ### bdwc_decim.sv
`timescale 1ns/100ps
module bdwc_decim
  import bdwc_pkg::*;
#(
  parameter int CNT_W = BDWC_DIV_CNT_W
)(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       internal_sample_rate,
  input  wire logic [3:0] div_sel,
  output logic            output_sample_rate
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] base;
  logic [CNT_W-1:0] lim;
  logic [3:0]       sel_q;
  logic             tick_q;
  logic             tick_d;

  // Counter restarts whenever the divider select changes
  always_comb begin
    lim    = CNT_W'(bdwc_divisor(div_sel) - 10'h001);
    base   = (div_sel != sel_q) ? '0 : cnt_q;
    cnt_d  = base;
    tick_d = 1'b0;
    if (internal_sample_rate) begin
      if (base >= lim) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = base + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= '0;
      sel_q  <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      sel_q  <= div_sel;
      tick_q <= tick_d;
    end
  end

  assign output_sample_rate = tick_q;

  out_after_in_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    output_sample_rate |-> $past(internal_sample_rate))
    else $error("output tick without internal tick");

  div_two_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (div_sel == 4'h1 && sel_q == 4'h1 && internal_sample_rate && cnt_q == '0)
      |=> !output_sample_rate)
    else $error("divide by two ticked early");

endmodule

// ### bdwc_core.sv
`timescale 1ns/100ps
module bdwc_core
  import bdwc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       sclk_pin,
  input  wire logic       frame_b_pin,
  input  wire logic       addr_load,
  input  wire logic [7:0] addr_load_val,
  input  wire logic       rd_dir,
  input  wire logic       wr_strobe,
  input  wire logic [7:0] wr_data,
  input  wire logic       queue_en,
  input  wire logic [5:0] read_count,
  input  wire logic       internal_sample_rate,
  output logic      [7:0] ctrl_value,
  output logic      [7:0] reg_ptr,
  output logic            byte_end,
  output logic            adc_tick,
  output logic            output_sample_rate,
  output logic            sample_pop,
  output logic      [5:0] samples_read
);

  // Pointer step with optional read wrap
  function automatic logic [7:0] bdwc_next_ptr(input logic [7:0] p, input logic rd,
                                               input logic [7:0] c);
    logic [7:0] wrap_at;
    wrap_at = c[BDWC_WRAP_SEL_BIT] ? BDWC_IFLAG_ADDR : BDWC_Z_HIGH_ADDR;
    if (rd && !c[BDWC_WRAP_DIS_BIT] && (p == wrap_at)) begin
      return BDWC_X_LOW_ADDR;
    end
    return p + 8'h01;
  endfunction

  // Samples allowed in one queue read
  function automatic logic [5:0] bdwc_sample_limit(input logic burst, input logic [5:0] cnt);
    logic [5:0] l;
    l = 6'h01;
    if (burst) begin
      if (cnt > BDWC_MAX_BURST) begin
        l = BDWC_MAX_BURST;
      end else if (cnt != 6'h00) begin
        l = cnt;
      end
    end
    return l;
  endfunction

  // Pin synchronisers
  logic        sclk_s1_q;
  logic        sclk_s2_q;
  logic        sclk_s3_q;
  logic        frm_s1_q;
  logic        frm_s2_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      frm_s1_q  <= 1'b1;
      frm_s2_q  <= 1'b1;
    end else begin
      sclk_s1_q <= sclk_pin;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      frm_s1_q  <= frame_b_pin;
      frm_s2_q  <= frm_s1_q;
    end
  end

  logic sclk_rise;
  assign sclk_rise = sclk_s2_q && !sclk_s3_q;

  // Frame tracking and bit counting
  bdwc_state_e state_q;
  bdwc_state_e state_d;
  logic [2:0]  bit_q;
  logic [2:0]  bit_d;
  logic        byte_done;

  always_comb begin
    state_d   = state_q;
    bit_d     = bit_q;
    byte_done = 1'b0;
    unique case (state_q)
      BDWC_IDLE: begin
        bit_d = 3'h0;
        if (!frm_s2_q) begin
          state_d = BDWC_XFER;
        end
      end
      BDWC_XFER: begin
        if (frm_s2_q) begin
          state_d = BDWC_IDLE;
          bit_d   = 3'h0;
        end else if (sclk_rise) begin
          bit_d     = bit_q + 3'h1;
          byte_done = (bit_q == BDWC_LAST_BIT);
        end
      end
      default: begin
        state_d = BDWC_IDLE;
        bit_d   = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= BDWC_IDLE;
      bit_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      bit_q   <= bit_d;
    end
  end

  // Control register and address pointer
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic       byte_end_q;

  always_comb begin
    ctrl_d = ctrl_q;
    ptr_d  = ptr_q;
    if (wr_strobe && (ptr_q == BDWC_CTRL_ADDR)) begin
      ctrl_d = wr_data;
    end
    if (addr_load) begin
      ptr_d = addr_load_val;
    end else if (byte_done) begin
      ptr_d = bdwc_next_ptr(ptr_q, rd_dir, ctrl_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q     <= BDWC_CTRL_RESET;
      ptr_q      <= 8'h00;
      byte_end_q <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      ptr_q      <= ptr_d;
      byte_end_q <= byte_done;
    end
  end

  // Queue drain accounting
  logic       drain_q;
  logic       drain_d;
  logic [2:0] sbyte_q;
  logic [2:0] sbyte_d;
  logic [5:0] samp_q;
  logic [5:0] samp_d;
  logic [5:0] limit_q;
  logic [5:0] limit_d;
  logic       pop_q;
  logic       pop_d;

  always_comb begin
    drain_d = drain_q;
    sbyte_d = sbyte_q;
    samp_d  = samp_q;
    limit_d = limit_q;
    pop_d   = 1'b0;
    if (state_q == BDWC_IDLE) begin
      drain_d = 1'b0;
      sbyte_d = 3'h0;
    end else if (addr_load) begin
      drain_d = rd_dir && queue_en && (addr_load_val == BDWC_X_LOW_ADDR);
      limit_d = bdwc_sample_limit(ctrl_q[BDWC_BURST_BIT], read_count);
      samp_d  = 6'h00;
      sbyte_d = 3'h0;
    end else if (byte_done && rd_dir && drain_q) begin
      if (sbyte_q == BDWC_SAMPLE_BYTES - 3'h1) begin
        sbyte_d = 3'h0;
        pop_d   = 1'b1;
        samp_d  = samp_q + 6'h01;
        if ((samp_q + 6'h01) == limit_q) begin
          drain_d = 1'b0;
        end
      end else begin
        sbyte_d = sbyte_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      drain_q <= 1'b0;
      sbyte_q <= 3'h0;
      samp_q  <= 6'h00;
      limit_q <= 6'h01;
      pop_q   <= 1'b0;
    end else begin
      drain_q <= drain_d;
      sbyte_q <= sbyte_d;
      samp_q  <= samp_d;
      limit_q <= limit_d;
      pop_q   <= pop_d;
    end
  end

  // Converter path keeps the undivided rate
  logic adc_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      adc_q <= 1'b0;
    end else begin
      adc_q <= internal_sample_rate;
    end
  end

  bdwc_decim #(
    .CNT_W (BDWC_DIV_CNT_W)
  ) bdwc_decim_inst (
    .clk_sys              (clk_sys),
    .rst_b                (rst_b),
    .internal_sample_rate (internal_sample_rate),
    .div_sel              (ctrl_q[BDWC_DIV_LSB +: BDWC_DIV_W]),
    .output_sample_rate   (output_sample_rate)
  );

  assign ctrl_value   = ctrl_q;
  assign reg_ptr      = ptr_q;
  assign byte_end     = byte_end_q;
  assign adc_tick     = adc_q;
  assign sample_pop   = pop_q;
  assign samples_read = samp_q;

  // Checks
  sequence frame_open_s;
    state_q == BDWC_IDLE && !frm_s2_q;
  endsequence

  sequence wr_ctrl_s;
    wr_strobe && !addr_load && ptr_q == BDWC_CTRL_ADDR;
  endsequence

  sequence rd_at_wrap_s(logic [7:0] a, logic sel);
    byte_done && !addr_load && rd_dir && !ctrl_q[BDWC_WRAP_DIS_BIT]
      && ctrl_q[BDWC_WRAP_SEL_BIT] == sel && ptr_q == a;
  endsequence

  frame_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    frame_open_s |=> state_q == BDWC_XFER ##0 bit_q == 3'h0)
    else $error("frame did not open");

  byte_in_xfer_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    byte_done |-> state_q == BDWC_XFER && bit_q == BDWC_LAST_BIT)
    else $error("byte end outside a frame");

  ctrl_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_ctrl_s |=> ctrl_q == $past(wr_data) ##1 ctrl_value == $past(wr_data, 2))
    else $error("control write lost");

  wrap_zhigh_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rd_at_wrap_s(BDWC_Z_HIGH_ADDR, 1'b0) |=> ptr_q == BDWC_X_LOW_ADDR)
    else $error("no wrap after Z high byte");

  wrap_iflag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rd_at_wrap_s(BDWC_Z_HIGH_ADDR, 1'b1) |=> ptr_q == BDWC_Z_HIGH_ADDR + 8'h01)
    else $error("wrapped early at Z high byte");

  ptr_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (byte_done && !addr_load && ctrl_q[BDWC_WRAP_DIS_BIT]) |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not step");

  single_sample_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (addr_load && state_q == BDWC_XFER && !ctrl_q[BDWC_BURST_BIT]) |=> limit_q == 6'h01)
    else $error("single read allows more than one sample");

  burst_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample_pop |-> samples_read <= limit_q && limit_q <= BDWC_MAX_BURST)
    else $error("burst exceeded its limit");

  adc_rate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    internal_sample_rate |=> adc_tick)
    else $error("converter tick dropped");

  undivided_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (internal_sample_rate && ctrl_q[BDWC_DIV_LSB +: BDWC_DIV_W] == 4'h0)
      |=> output_sample_rate)
    else $error("undivided rate not passed through");

endmodule

// ### bdwc_host.sv
`timescale 1ns/100ps
module bdwc_host
  import bdwc_pkg::*;
(
  input  wire logic       clk_sys,
  output logic            sclk_pin,
  output logic            frame_b_pin,
  output logic            addr_load,
  output logic      [7:0] addr_load_val,
  output logic            rd_dir,
  output logic            wr_strobe,
  output logic      [7:0] wr_data
);
  // Serial clock rests low outside frames
  initial begin
    sclk_pin = 1'b0;
    frame_b_pin = 1'b1;
    addr_load = 1'b0;
    addr_load_val = 8'h5A;
    rd_dir = 1'b0;
    wr_strobe = 1'b0;
    wr_data = 8'hA5;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic open_frame(input logic [7:0] a, input logic rd);
    frame_b_pin = 1'b0;
    rd_dir = rd;
    wait_n(4);
    addr_load = 1'b1;
    addr_load_val = a;
    wait_n(1);
    addr_load = 1'b0;
    addr_load_val = ~a;
    wait_n(1);
  endtask

  // One byte, 200 ns serial period
  task automatic shift_byte();
    repeat (8) begin
      sclk_pin = 1'b1;
      wait_n(4);
      sclk_pin = 1'b0;
      wait_n(4);
    end
  endtask

  task automatic close_frame();
    frame_b_pin = 1'b1;
    rd_dir = 1'b0;
    wait_n(4);
  endtask

  task automatic write_ctrl(input logic [7:0] d);
    open_frame(BDWC_CTRL_ADDR, 1'b0);
    wr_strobe = 1'b1;
    wr_data = d & 8'hBF;
    wait_n(1);
    wr_strobe = 1'b0;
    wr_data = ~wr_data;
    close_frame();
  endtask
endmodule

// ### bdwc_core_tb.sv
`timescale 1ns/100ps
module bdwc_core_tb;
  import bdwc_pkg::*;
  logic       clk_sys;
  logic       rst_b;
  logic       queue_en;
  logic [5:0] read_count;
  logic       internal_sample_rate;
  wire        sclk_pin;
  wire        frame_b_pin;
  wire        addr_load;
  wire  [7:0] addr_load_val;
  wire        rd_dir;
  wire        wr_strobe;
  wire  [7:0] wr_data;
  logic [7:0] ctrl_value;
  logic [7:0] reg_ptr;
  logic       output_sample_rate;
  logic       adc_tick;
  logic       byte_end;
  logic       sample_pop;
  logic [5:0] samples_read;
  int         errors;
  int         checks;
  int         n_out;
  int         n_adc;
  int         n_pop;
  int         n_byte;
  logic [9:0] div_row [16] = '{10'h001, 10'h002, 10'h004, 10'h005, 10'h008, 10'h00A,
    10'h010, 10'h014, 10'h028, 10'h043, 10'h050, 10'h064, 10'h0C8, 10'h0FA, 10'h1F4,
    10'h3E8};

  bdwc_host bdwc_host_inst (.clk_sys(clk_sys), .sclk_pin(sclk_pin),
    .frame_b_pin(frame_b_pin), .addr_load(addr_load), .addr_load_val(addr_load_val),
    .rd_dir(rd_dir), .wr_strobe(wr_strobe), .wr_data(wr_data));

  bdwc_core bdwc_core_inst (.clk_sys(clk_sys), .rst_b(rst_b), .sclk_pin(sclk_pin),
    .frame_b_pin(frame_b_pin), .addr_load(addr_load), .addr_load_val(addr_load_val),
    .rd_dir(rd_dir), .wr_strobe(wr_strobe), .wr_data(wr_data), .queue_en(queue_en),
    .read_count(read_count), .internal_sample_rate(internal_sample_rate),
    .ctrl_value(ctrl_value), .reg_ptr(reg_ptr), .byte_end(byte_end), .adc_tick(adc_tick),
    .output_sample_rate(output_sample_rate), .sample_pop(sample_pop),
    .samples_read(samples_read));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (output_sample_rate === 1'b1) n_out++;
    if (adc_tick === 1'b1) n_adc++;
    if (sample_pop === 1'b1) n_pop++;
    if (byte_end === 1'b1) n_byte++;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Ticks with a varying idle gap, standing in for different base rates
  task automatic in_ticks(input int n, input int gap);
    repeat (n) begin
      internal_sample_rate = 1'b1;
      @(negedge clk_sys);
      internal_sample_rate = 1'b0;
      repeat (gap) @(negedge clk_sys);
    end
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic wrap_case(input logic [7:0] c, input logic [7:0] a, input logic [31:0] e);
    bdwc_host_inst.write_ctrl(c);
    bdwc_host_inst.open_frame(a, 1'b1);
    for (int k = 3; k >= 0; k--) begin
      bdwc_host_inst.shift_byte();
      check("reg_ptr", 16'(reg_ptr), 16'(e[8*k +: 8]));
    end
    bdwc_host_inst.close_frame();
  endtask

  task automatic drain(input logic [7:0] c, input int nbytes, input logic [5:0] e);
    bdwc_host_inst.write_ctrl(c);
    bdwc_host_inst.open_frame(BDWC_X_LOW_ADDR, 1'b1);
    n_pop = 0;
    n_byte = 0;
    repeat (nbytes) bdwc_host_inst.shift_byte();
    check("samples_read", 16'(samples_read), 16'(e));
    check("sample_pop", 16'(n_pop), 16'(e));
    check("byte_end", 16'(n_byte), 16'(nbytes));
    bdwc_host_inst.close_frame();
  endtask

  initial begin
    rst_b = 1'b0;
    queue_en = 1'b1;
    read_count = 6'h01;
    internal_sample_rate = 1'b0;
    errors = 0;
    checks = 0;
    repeat (2) @(negedge clk_sys);
    check("ctrl_value", 16'(ctrl_value), 16'(BDWC_CTRL_RESET));
    check("reg_ptr", 16'(reg_ptr), 16'h0000);
    check("samples_read", 16'(samples_read), 16'h0000);
    rst_b = 1'b1;
    @(negedge clk_sys);
    // Divider table
    for (int i = 0; i < 16; i++) begin
      bdwc_host_inst.write_ctrl(8'(i));
      check("ctrl_value", 16'(ctrl_value), 16'(i));
      n_out = 0;
      n_adc = 0;
      in_ticks(2 * int'(div_row[i]) - 1, 1 + i % 3);
      check("out_count", 16'(n_out), 16'h0001);
      in_ticks(1, 1 + i % 3);
      check("out_count", 16'(n_out), 16'h0002);
      check("adc_count", 16'(n_adc), 16'(2 * int'(div_row[i])));
    end
    // Pointer wrap points
    wrap_case(8'h00, 8'h10, 32'h11120D0E);
    wrap_case(8'h20, 8'h12, 32'h13140D0E);
    wrap_case(8'h10, 8'h12, 32'h13141516);
    // Queue drains; read count set before burst
    drain(8'h00, 12, 6'h01);
    queue_en = 1'b0;
    drain(8'h80, 12, 6'h00);
    queue_en = 1'b1;
    read_count = 6'h02;
    drain(8'h80, 18, 6'h02);
    read_count = 6'h20;
    drain(8'h80, 198, 6'h20);
    // Reset in mid-run
    bdwc_host_inst.write_ctrl(8'h9F);
    check("ctrl_value", 16'(ctrl_value), 16'h009F);
    rst_b = 1'b0;
    @(negedge clk_sys);
    check("ctrl_value", 16'(ctrl_value), 16'(BDWC_CTRL_RESET));
    check("reg_ptr", 16'(reg_ptr), 16'h0000);
    check("samples_read", 16'(samples_read), 16'h0000);
    rst_b = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("ctrl_value", 16'(ctrl_value), 16'(BDWC_CTRL_RESET));
    check("reg_ptr", 16'(reg_ptr), 16'h0000);
    n_out = 0;
    in_ticks(1, 1);
    check("out_count", 16'(n_out), 16'h0001);
    close_out();
  end

  initial begin
    #2000000;
    errors++;
    close_out();
  end
endmodule
